/* core/gpib_bridge.sv */
`timescale 1ns/100ps
`include "gpib_cfg.svh"

// What this block does
// - Decode sixteen consecutive host addresses
// - Switch zero gives 8400H to 840FH
// - Board select low when both terms low
// - A3 picks engine or controller port select
// - A2..A0 pick one of eight registers
// - Read/write sets host buffer direction
// - Transceivers drive when talking, receive listening
// - Command message forces transceivers to drive
// - Reading switch register pulls enable low
// - One byte over eight parallel lines
// - Talker waits RFD; unready listener holds low
// - Talker places byte, then asserts DAV
// - DAC rises after byte is accepted
// - ATN byte is a controller command
// - Talk command carries device number low
// - Talk interrupt held until byte supplied
// - Listen interrupt per received byte
module gpib_bridge
  import gpib_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Host bus
  input  wire logic [15:0] host_addr,
  input  wire logic        host_valid,
  input  wire logic        host_rw,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             board_select_n,
  output logic             talk_listen_select_n,
  output logic             ctrl_port_select_n,
  output logic             host_buf_enable,
  output logic             host_buf_to_host,
  output logic             irq_n,
  // Switches
  input  wire logic [3:0]  base_switch,
  input  wire logic [4:0]  addr_switch,
  output logic             addr_switch_enable_n,
  // Instrument bus
  input  wire logic [7:0]  dio_in,
  output logic      [7:0]  dio_out,
  output logic             dio_oe,
  input  wire logic        dav_in,
  output logic             dav_out,
  output logic             dav_oe,
  input  wire logic        rfd_in,
  output logic             rfd_out,
  output logic             rfd_oe,
  input  wire logic        dac_in,
  output logic             dac_out,
  output logic             dac_oe,
  input  wire logic        atn_in,
  output logic             atn_out,
  output logic             atn_oe,
  input  wire logic [3:0]  misc_in,
  output logic      [3:0]  misc_out,
  output logic      [3:0]  misc_oe,
  output logic             transceiver_drive_out
);
  // Synchronised pins
  logic [7:0]  dio_s;
  logic        dav_s;
  logic        rfd_s;
  logic        dac_s;
  logic        atn_s;
  logic [3:0]  misc_s;
  logic [3:0]  base_s;
  logic [4:0]  addr_sw_s;

  gpib_sync #(.WIDTH(16)) u_bus_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({misc_in, atn_in, dac_in, rfd_in, dav_in, dio_in}),
    .sync_out ({misc_s, atn_s, dac_s, rfd_s, dav_s, dio_s})
  );

  gpib_sync #(.WIDTH(9)) u_sw_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({base_switch, addr_switch}),
    .sync_out ({base_s, addr_sw_s})
  );

  // Block base moves in steps of sixteen addresses with the switch
  function automatic logic [15:0] block_base(input logic [3:0] pos);
    block_base = `GPIB_BASE_ADDR + {8'h00, pos, 4'h0};
  endfunction

  // Host address decode
  logic [15:0] base;
  logic        term_hi_n;
  logic        term_lo_n;
  logic [2:0]  idx;
  logic        tl_sel;
  logic        cp_sel;
  logic        tl_wr;
  logic        tl_rd;
  logic        cp_wr;

  always_comb begin
    base      = block_base(base_s);
    term_hi_n = (host_addr[15:8] != base[15:8]);
    term_lo_n = (host_addr[7:4] != base[7:4]);
    board_select_n = term_hi_n | term_lo_n;
    talk_listen_select_n = board_select_n | host_addr[`GPIB_UNIT_BIT];
    ctrl_port_select_n   = board_select_n | ~host_addr[`GPIB_UNIT_BIT];
    idx    = host_addr[`GPIB_IDX_MSB:0];
    tl_sel = host_valid & ~talk_listen_select_n;
    cp_sel = host_valid & ~ctrl_port_select_n;
    tl_wr  = tl_sel & ~host_rw;
    tl_rd  = tl_sel & host_rw;
    cp_wr  = cp_sel & ~host_rw;
    host_buf_enable  = ~board_select_n;
    host_buf_to_host = ~board_select_n & host_rw;
    addr_switch_enable_n = ~(tl_rd & (idx == `GPIB_TL_SWITCH));
  end

  // Engine and controller port state
  gpib_src_e   src_reg;
  gpib_src_e   src_next;
  gpib_acc_e   acc_reg;
  gpib_acc_e   acc_next;
  logic [1:0]  cnt_reg;
  logic [1:0]  cnt_next;
  logic        talk_reg;
  logic        talk_next;
  logic        listen_reg;
  logic        listen_next;
  logic        tx_full_reg;
  logic        tx_full_next;
  logic        rx_full_reg;
  logic        rx_full_next;
  gpib_byte_t  tx_reg;
  gpib_byte_t  tx_next;
  gpib_byte_t  rx_reg;
  gpib_byte_t  rx_next;
  gpib_byte_t  cmd_reg;
  gpib_byte_t  cmd_next;
  logic [4:0]  my_addr_reg;
  logic [4:0]  my_addr_next;
  gpib_byte_t  cp_data_reg;
  gpib_byte_t  cp_data_next;
  gpib_byte_t  cp_lines_reg;
  gpib_byte_t  cp_lines_next;
  logic        cp_en_reg;
  logic        cp_en_next;
  gpib_byte_t  rdata_reg;
  gpib_byte_t  rdata_next;

  logic        acc_active;
  logic        acc_ready;
  logic        capture;
  logic        src_drive;

  always_comb begin
    src_next      = src_reg;
    acc_next      = acc_reg;
    cnt_next      = cnt_reg;
    talk_next     = talk_reg;
    listen_next   = listen_reg;
    tx_full_next  = tx_full_reg;
    rx_full_next  = rx_full_reg;
    tx_next       = tx_reg;
    rx_next       = rx_reg;
    cmd_next      = cmd_reg;
    my_addr_next  = my_addr_reg;
    cp_data_next  = cp_data_reg;
    cp_lines_next = cp_lines_reg;
    cp_en_next    = cp_en_reg;
    rdata_next    = rdata_reg;

    // Commands are always heard; data only while addressed to listen
    acc_active = atn_s | listen_reg;
    acc_ready  = atn_s | ~rx_full_reg;
    capture    = 1'b0;

    // Acceptor
    case (acc_reg)
      GPIB_ACC_READY: begin
        if (acc_active && acc_ready && dav_s) begin
          capture  = 1'b1;
          acc_next = GPIB_ACC_WAIT_DAV_LOW;
        end
      end
      GPIB_ACC_WAIT_DAV_LOW: begin
        if (!dav_s) begin
          acc_next = GPIB_ACC_READY;
        end
      end
      default: acc_next = GPIB_ACC_READY;
    endcase

    // Clears first so that a same-cycle set wins
    if (tl_rd && idx == `GPIB_TL_DATA) begin
      rx_full_next = 1'b0;
    end

    if (capture) begin
      if (atn_s) begin
        cmd_next = dio_s;
        if (dio_s == `GPIB_CMD_UNLISTEN) begin
          listen_next = 1'b0;
        end else if (dio_s == `GPIB_CMD_UNTALK) begin
          talk_next = 1'b0;
        end else if ((dio_s & `GPIB_CMD_GRP_MASK) == `GPIB_CMD_TALK) begin
          talk_next = ((dio_s & `GPIB_ADDR_MASK) == {3'h0, my_addr_reg});
        end else if ((dio_s & `GPIB_CMD_GRP_MASK) == `GPIB_CMD_LISTEN) begin
          if ((dio_s & `GPIB_ADDR_MASK) == {3'h0, my_addr_reg}) begin
            listen_next = 1'b1;
          end
        end
      end else begin
        rx_next      = dio_s;
        rx_full_next = 1'b1;
      end
    end

    // Source
    case (src_reg)
      GPIB_SRC_IDLE: begin
        if (talk_reg && tx_full_reg && !atn_s) begin
          src_next = GPIB_SRC_WAIT_RFD;
        end
      end
      GPIB_SRC_WAIT_RFD: begin
        if (atn_s) begin
          src_next = GPIB_SRC_IDLE;
        end else if (rfd_s) begin
          cnt_next = `GPIB_RST_CNT;
          src_next = GPIB_SRC_SETTLE;
        end
      end
      GPIB_SRC_SETTLE: begin
        // Data lines settle before DAV is raised
        if (cnt_reg == 2'(`GPIB_SETTLE_CYC - 1)) begin
          src_next = GPIB_SRC_DAV;
        end else begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
      GPIB_SRC_DAV: begin
        if (dac_s) begin
          tx_full_next = 1'b0;
          src_next     = GPIB_SRC_END;
        end
      end
      GPIB_SRC_END: begin
        if (!dac_s) begin
          src_next = GPIB_SRC_IDLE;
        end
      end
      default: src_next = GPIB_SRC_IDLE;
    endcase

    // Host writes; a byte is never replaced mid-transfer
    if (tl_wr) begin
      case (idx)
        `GPIB_TL_DATA: begin
          if (!tx_full_reg) begin
            tx_next      = host_wdata;
            tx_full_next = 1'b1;
          end
        end
        `GPIB_TL_MY_ADDR: my_addr_next = host_wdata[4:0];
        default: ;
      endcase
    end
    if (cp_wr) begin
      case (idx)
        `GPIB_CP_DATA_OUT:  cp_data_next  = host_wdata;
        `GPIB_CP_LINES_OUT: cp_lines_next = host_wdata;
        `GPIB_CP_ENABLE:    cp_en_next    = host_wdata[0];
        default: ;
      endcase
    end

    // Host reads, registered
    if (tl_rd) begin
      case (idx)
        `GPIB_TL_DATA:     rdata_next = rx_reg;
        `GPIB_TL_STATUS:   rdata_next = {3'h0, atn_s, rx_full_reg, tx_full_reg,
                                         listen_reg, talk_reg};
        `GPIB_TL_MY_ADDR:  rdata_next = {3'h0, my_addr_reg};
        `GPIB_TL_LAST_CMD: rdata_next = cmd_reg;
        `GPIB_TL_SWITCH:   rdata_next = {3'h0, addr_sw_s};
        default:           rdata_next = `GPIB_RST_BYTE;
      endcase
    end else if (cp_sel && host_rw) begin
      case (idx)
        `GPIB_CP_DATA_OUT:  rdata_next = cp_data_reg;
        `GPIB_CP_LINES_OUT: rdata_next = cp_lines_reg;
        `GPIB_CP_DATA_IN:   rdata_next = dio_s;
        `GPIB_CP_LINES_IN:  rdata_next = {misc_s, atn_s, dac_s, rfd_s, dav_s};
        `GPIB_CP_ENABLE:    rdata_next = {7'h00, cp_en_reg};
        default:            rdata_next = `GPIB_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_reg      <= GPIB_SRC_IDLE;
      acc_reg      <= GPIB_ACC_READY;
      cnt_reg      <= `GPIB_RST_CNT;
      talk_reg     <= 1'b0;
      listen_reg   <= 1'b0;
      tx_full_reg  <= 1'b0;
      rx_full_reg  <= 1'b0;
      tx_reg       <= `GPIB_RST_BYTE;
      rx_reg       <= `GPIB_RST_BYTE;
      cmd_reg      <= `GPIB_RST_BYTE;
      my_addr_reg  <= `GPIB_RST_ADDR;
      cp_data_reg  <= `GPIB_RST_BYTE;
      cp_lines_reg <= `GPIB_RST_BYTE;
      cp_en_reg    <= 1'b0;
      rdata_reg    <= `GPIB_RST_BYTE;
    end else begin
      src_reg      <= src_next;
      acc_reg      <= acc_next;
      cnt_reg      <= cnt_next;
      talk_reg     <= talk_next;
      listen_reg   <= listen_next;
      tx_full_reg  <= tx_full_next;
      rx_full_reg  <= rx_full_next;
      tx_reg       <= tx_next;
      rx_reg       <= rx_next;
      cmd_reg      <= cmd_next;
      my_addr_reg  <= my_addr_next;
      cp_data_reg  <= cp_data_next;
      cp_lines_reg <= cp_lines_next;
      cp_en_reg    <= cp_en_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Pin drive; RFD and DAC are wired-AND, only ever pulled low
  always_comb begin
    src_drive  = (src_reg == GPIB_SRC_SETTLE) || (src_reg == GPIB_SRC_DAV);
    host_rdata = rdata_reg;
    transceiver_drive_out = talk_reg | cp_lines_reg[`GPIB_LN_ATN];
    dio_oe  = transceiver_drive_out & (src_drive | cp_en_reg);
    dio_out = cp_en_reg ? cp_data_reg : tx_reg;
    dav_out = 1'b1;
    dav_oe  = (src_reg == GPIB_SRC_DAV) | cp_lines_reg[`GPIB_LN_DAV];
    rfd_out = 1'b0;
    rfd_oe  = (acc_active & (~acc_ready | (acc_reg != GPIB_ACC_READY)))
              | cp_lines_reg[`GPIB_LN_RFD_HOLD];
    dac_out = 1'b0;
    dac_oe  = (acc_active & (acc_reg == GPIB_ACC_READY))
              | cp_lines_reg[`GPIB_LN_DAC_HOLD];
    atn_out  = 1'b1;
    atn_oe   = cp_lines_reg[`GPIB_LN_ATN];
    misc_out = 4'hf;
    misc_oe  = cp_lines_reg[7:`GPIB_LN_MISC_LSB];
    // Interrupt drops for an empty talk buffer outside ATN or an unread listen byte
    irq_n = ~((talk_reg & ~tx_full_reg & ~atn_s) | (listen_reg & rx_full_reg));
  end
endmodule // gpib_bridge

/* core/gpib_cfg.svh */
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH

// Clock and timing
`define GPIB_CLK_NS        40
`define GPIB_SETTLE_NS     100
`define GPIB_SETTLE_CYC    ((`GPIB_SETTLE_NS + `GPIB_CLK_NS - 1) / `GPIB_CLK_NS)

// Host address decode
`define GPIB_BASE_ADDR     16'h8400
`define GPIB_UNIT_BIT      3
`define GPIB_IDX_MSB       2

// Talker/listener engine register indices
`define GPIB_TL_DATA       3'h0
`define GPIB_TL_STATUS     3'h1
`define GPIB_TL_MY_ADDR    3'h2
`define GPIB_TL_LAST_CMD   3'h3
`define GPIB_TL_SWITCH     3'h7

// Controller port register indices
`define GPIB_CP_DATA_OUT   3'h0
`define GPIB_CP_LINES_OUT  3'h1
`define GPIB_CP_DATA_IN    3'h2
`define GPIB_CP_LINES_IN   3'h3
`define GPIB_CP_ENABLE     3'h4

// Controller port line bit positions
`define GPIB_LN_DAV        0
`define GPIB_LN_RFD_HOLD   1
`define GPIB_LN_DAC_HOLD   2
`define GPIB_LN_ATN        3
`define GPIB_LN_MISC_LSB   4

// Status bit positions
`define GPIB_ST_TALK       0
`define GPIB_ST_LISTEN     1
`define GPIB_ST_TX_FULL    2
`define GPIB_ST_RX_FULL    3
`define GPIB_ST_ATN        4

// Command decode
`define GPIB_CMD_GRP_MASK  8'h60
`define GPIB_CMD_LISTEN    8'h20
`define GPIB_CMD_TALK      8'h40
`define GPIB_CMD_UNLISTEN  8'h3f
`define GPIB_CMD_UNTALK    8'h5f
`define GPIB_ADDR_MASK     8'h1f

// Reset values
`define GPIB_RST_BYTE      8'h00
`define GPIB_RST_ADDR      5'h00
`define GPIB_RST_CNT       2'h0

`endif

/* core/gpib_pkg.sv */
package gpib_pkg;
  typedef enum logic [2:0] {
    GPIB_SRC_IDLE,
    GPIB_SRC_WAIT_RFD,
    GPIB_SRC_SETTLE,
    GPIB_SRC_DAV,
    GPIB_SRC_END
  } gpib_src_e;

  typedef enum logic [1:0] {
    GPIB_ACC_READY,
    GPIB_ACC_WAIT_DAV_LOW
  } gpib_acc_e;

  typedef logic [7:0] gpib_byte_t;
endpackage

/* core/gpib_sync.sv */
`timescale 1ns/100ps
module gpib_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // gpib_sync

/* dv/gpib_bridge_checker.sv */
`timescale 1ns/100ps
module gpib_bridge_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Host side
  input wire logic [15:0] host_addr,
  input wire logic        host_valid,
  input wire logic        host_rw,
  input wire logic        board_select_n,
  input wire logic        talk_listen_select_n,
  input wire logic        ctrl_port_select_n,
  input wire logic        host_buf_enable,
  input wire logic        host_buf_to_host,
  input wire logic        irq_n,
  input wire logic [3:0]  base_switch,
  input wire logic        addr_switch_enable_n,
  // Instrument side
  input wire logic        dio_oe,
  input wire logic        dav_in,
  input wire logic        dav_oe,
  input wire logic        rfd_in,
  input wire logic        rfd_oe,
  input wire logic        dac_oe,
  input wire logic        atn_in,
  input wire logic        atn_oe,
  input wire logic        transceiver_drive_out
);
  logic [3:0] sw_prev_reg;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;

  // Base decode is only judged once the switch synchronizer has caught up
  always_comb settle_next = (base_switch != sw_prev_reg) ? 2'h0 :
                            ((settle_reg == 2'h3) ? 2'h3 : settle_reg + 2'h1);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_reg  <= 2'h0;
      sw_prev_reg <= 4'h0;
    end else begin
      settle_reg  <= settle_next;
      sw_prev_reg <= base_switch;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_board_sel: assert property (settle_reg == 2'h3 |->
    board_select_n == (host_addr[15:4] != 12'h840 + {8'h00, base_switch}))
    else $error("board select wrong");
  chk_unit_sel: assert property (talk_listen_select_n == (board_select_n | host_addr[3]) &&
    ctrl_port_select_n == (board_select_n | !host_addr[3])) else $error("unit select wrong");
  chk_buf_dir: assert property (host_buf_enable == !board_select_n &&
    host_buf_to_host == (!board_select_n && host_rw)) else $error("buffer direction wrong");
  chk_switch_gate: assert property (addr_switch_enable_n ==
    !(host_valid && host_rw && !talk_listen_select_n && host_addr[2:0] == 3'h7))
    else $error("switch enable wrong");
  chk_cmd_drive: assert property (atn_oe |-> transceiver_drive_out)
    else $error("command not driven out");
  chk_talk_drive: assert property (dav_oe && !atn_oe |-> transceiver_drive_out && dio_oe)
    else $error("talker not driving");
  chk_data_first: assert property ($rose(dav_oe) |-> $past(dio_oe, 3) && $past(rfd_in, 5))
    else $error("valid raised too early");
  chk_dac_release: assert property ($rose(dav_in) && dac_oe && !rfd_oe |->
    dac_oe [*3] ##1 !dac_oe) else $error("accept release timing wrong");
  chk_rfd_hold: assert property ($fell(dac_oe) && $past(dav_in, 3) |-> rfd_oe)
    else $error("ready not held after capture");
  chk_listen_irq: assert property ($fell(dac_oe) && !atn_in && !$past(atn_in, 4)
    |-> !irq_n) else $error("no interrupt on data byte");
endmodule // gpib_bridge_checker

bind gpib_bridge gpib_bridge_checker chk (.*);

/* dv/gpib_peer_model.sv */
`timescale 1ns/100ps
module gpib_peer_model (
  // Clock
  input  wire logic       clock,
  // Resolved bus
  input  wire logic [7:0] dio_in,
  input  wire logic       dav_in,
  input  wire logic       rfd_in,
  input  wire logic       dac_in,
  // Peer drive
  output logic      [7:0] p_dio,
  output logic            p_dav,
  output logic            p_atn,
  output logic            p_rfd_low,
  output logic            p_dac_low
);
  initial begin
    p_dio = 8'h00;
    p_dav = 1'b0;
    p_atn = 1'b0;
    p_rfd_low = 1'b1;
    p_dac_low = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Extra wait lets the far end see ATN before the byte goes out
  task automatic send_byte(input logic [7:0] b, input logic atn, input int slow, output logic ok);
    int t;
    p_atn = atn;
    p_rfd_low = 1'b0;
    p_dac_low = 1'b0;
    step(slow + 3);
    for (t = 0; t < 300 && rfd_in !== 1'b1; t++) step(1);
    p_dio = b;
    step(2);
    p_dav = 1'b1;
    for (t = 0; t < 300 && dac_in !== 1'b1; t++) step(1);
    ok = dac_in;
    p_dav = 1'b0;
    // Released lines change pattern so stale data never passes
    p_dio = ~b;
    step(1);
  endtask

  task automatic recv_byte(input int slow, output logic [7:0] b);
    int t;
    p_atn = 1'b0;
    // A listener holds both lines low until it is ready and has accepted
    p_rfd_low = 1'b1;
    p_dac_low = 1'b1;
    step(slow + 1);
    p_rfd_low = 1'b0;
    for (t = 0; t < 300 && dav_in !== 1'b1; t++) step(1);
    b = dio_in;
    p_rfd_low = 1'b1;
    step(slow + 1);
    p_dac_low = 1'b0;
    for (t = 0; t < 300 && dav_in !== 1'b0; t++) step(1);
    p_dac_low = 1'b1;
    step(1);
  endtask
endmodule // gpib_peer_model

/* dv/gpib_tb.sv */
`timescale 1ns/100ps
module testbench;
  logic        clock, rst, host_valid, host_rw, board_select_n, talk_listen_select_n, sw_en;
  logic        ctrl_port_select_n, host_buf_enable, host_buf_to_host, irq_n, ok;
  logic        addr_switch_enable_n, dio_oe, dav_in, dav_out, dav_oe, rfd_in, rfd_out, rfd_oe;
  logic        dac_in, dac_out, dac_oe, atn_in, atn_out, atn_oe, transceiver_drive_out;
  logic        p_dav, p_atn, p_rfd_low, p_dac_low;
  logic [15:0] host_addr, base;
  logic [7:0]  host_wdata, host_rdata, dio_in, dio_out, p_dio, rd, got;
  logic [4:0]  addr_switch;
  logic [3:0]  base_switch, misc_in, misc_out, misc_oe;
  int          fails, check_count, cycles;

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // Released data lines show the peer's pattern; wired-AND lines float high
  assign dio_in = dio_oe ? dio_out : p_dio;
  assign dav_in = (dav_oe & dav_out) | p_dav;
  assign atn_in = (atn_oe & atn_out) | p_atn;
  assign rfd_in = !((rfd_oe & !rfd_out) | p_rfd_low);
  assign dac_in = !((dac_oe & !dac_out) | p_dac_low);

  gpib_bridge uut (.*);
  gpib_peer_model peer (.*);

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Index bit 3 picks the controller port
  task automatic host(input logic [4:0] idx, input logic rw, input logic [7:0] wd);
    host_addr = base + {11'h000, idx};
    host_rw = rw;
    host_wdata = wd;
    host_valid = 1'b1;
    #1 sw_en = addr_switch_enable_n;
    step(1);
    rd = host_rdata;
    host_valid = 1'b0;
    step(1);
  endtask

  task automatic t_decode;
    int offs[6] = '{-1, 0, 7, 8, 15, 16};
    logic in_blk;
    for (int s = 0; s < 2; s++) begin
      base_switch = s ? 4'h3 : 4'h0;
      base = 16'h8400 + {8'h00, base_switch, 4'h0};
      step(4);
      for (int k = 0; k < 6; k++) begin
        in_blk = (k > 0 && k < 5);
        host_addr = base + 16'(offs[k]);
        host_rw = k[0];
        step(1);
        check("board", 8'(board_select_n), 8'(!in_blk));
        check("engine", 8'(talk_listen_select_n), 8'(!(in_blk && !host_addr[3])));
        check("port", 8'(ctrl_port_select_n), 8'(!(in_blk && host_addr[3])));
        check("buf", 8'({host_buf_enable, host_buf_to_host}), 8'({in_blk, in_blk & k[0]}));
      end
    end
    $display("test decode done");
  endtask

  task automatic t_switch;
    addr_switch = 5'h0b;
    step(3);
    host(5'h07, 1'b1, 8'h00);
    check("sw enable", 8'(sw_en), 8'h00);
    check("sw value", rd, 8'h0b);
    host(5'h02, 1'b0, rd);
    host(5'h02, 1'b1, 8'h00);
    check("my addr", rd, 8'h0b);
    host(5'h05, 1'b1, 8'h00);
    check("unmapped", rd, 8'h00);
    host(5'h0f, 1'b1, 8'h00);
    check("port sw enable", 8'(sw_en), 8'h01);
    $display("test switch done");
  endtask

  task automatic t_listen;
    peer.send_byte(8'h2b, 1'b1, 2, ok);
    check("cmd ack", 8'(ok), 8'h01);
    host(5'h03, 1'b1, 8'h00);
    check("last cmd", rd, 8'h2b);
    host(5'h01, 1'b1, 8'h00);
    check("listen", rd & 8'h02, 8'h02);
    peer.send_byte(8'ha5, 1'b0, 4, ok);
    check("rx irq", 8'(irq_n), 8'h00);
    host(5'h00, 1'b1, 8'h00);
    check("rx 1", rd, 8'ha5);
    check("irq off", 8'(irq_n), 8'h01);
    peer.send_byte(8'h5a, 1'b0, 0, ok);
    step(6);
    check("rfd held", 8'(rfd_in), 8'h00);
    host(5'h00, 1'b1, 8'h00);
    check("rx 2", rd, 8'h5a);
    step(4);
    check("rfd free", 8'(rfd_in), 8'h01);
    peer.send_byte(8'h3f, 1'b1, 0, ok);
    host(5'h01, 1'b1, 8'h00);
    check("unlisten", rd & 8'h02, 8'h00);
    $display("test listen done");
  endtask

  task automatic t_talk;
    peer.send_byte(8'h4b, 1'b1, 1, ok);
    fork
      peer.recv_byte(12, got);
      begin
        step(5);
        check("talk irq", 8'(irq_n), 8'h00);
        check("drive out", 8'(transceiver_drive_out), 8'h01);
        host(5'h00, 1'b0, 8'h3c);
        check("irq off", 8'(irq_n), 8'h01);
        host(5'h00, 1'b0, 8'hc3);
      end
    join
    check("tx byte", got, 8'h3c);
    step(3);
    check("irq again", 8'(irq_n), 8'h00);
    host(5'h01, 1'b1, 8'h00);
    check("tx empty", rd & 8'h05, 8'h01);
    peer.send_byte(8'h4a, 1'b1, 2, ok);
    host(5'h01, 1'b1, 8'h00);
    check("untalk", rd & 8'h01, 8'h00);
    check("receive dir", 8'(transceiver_drive_out), 8'h00);
    $display("test talk done");
  endtask

  task automatic t_ctrl;
    misc_in = 4'h5;
    host(5'h09, 1'b0, 8'h48);
    check("atn drive", 8'({atn_oe, transceiver_drive_out}), 8'h03);
    check("misc drive", 8'(misc_oe), 8'h04);
    host(5'h09, 1'b1, 8'h00);
    check("lines out", rd, 8'h48);
    host(5'h08, 1'b0, 8'h96);
    host(5'h0c, 1'b0, 8'h01);
    check("data out", dio_oe ? dio_out : 8'hxx, 8'h96);
    host(5'h0b, 1'b1, 8'h00);
    check("lines in", rd & 8'hf8, 8'h58);
    host(5'h09, 1'b0, 8'h00);
    host(5'h0c, 1'b0, 8'h00);
    check("released", 8'({dio_oe, transceiver_drive_out, misc_oe}), 8'h00);
    $display("test port done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run;
    end
  end

  initial begin
    rst = 1'b1;
    host_addr = 16'h0000;
    host_valid = 1'b0;
    host_rw = 1'b0;
    host_wdata = 8'h00;
    base_switch = 4'h0;
    addr_switch = 5'h00;
    misc_in = 4'h0;
    base = 16'h8400;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    step(2);
    t_decode;
    t_switch;
    t_listen;
    t_talk;
    t_ctrl;
    complete_run;
  end
endmodule // testbench
